/* src/checksum_engine.v */
// Bytewise CRC coprocessor, 8 or 16 bit, either bit order
`include "nvm_cmd_consts.vh"
`default_nettype none
module checksum_engine (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire load,
  input wire [15:0] seed,
  input wire short_sel,
  input wire msb_first,
  // Byte stream
  input wire byte_valid,
  input wire [7:0] byte_in,
  // Result
  output reg [15:0] crc_r
);
  reg [15:0] c;
  reg b;
  integer i;
  // One byte per cycle, bit loop unrolled by the tool
  always @* begin
    c = crc_r;
    b = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      b = msb_first ? byte_in[7 - i] : byte_in[i];
      if (short_sel) begin
        if (c[7] ^ b) begin
          c = {8'h00, c[6:0], 1'b0} ^ {8'h00, `POLY8}; // [RL19]
        end else begin
          c = {8'h00, c[6:0], 1'b0};
        end
      end else begin
        if (c[15] ^ b) begin
          c = {c[14:0], 1'b0} ^ `POLY16; // [RL20]
        end else begin
          c = {c[14:0], 1'b0};
        end
      end
    end
  end
  // Seed on load, else accumulate
  always @(posedge aclk) begin
    if (!aresetn) begin
      crc_r <= 16'h0000;
    end else if (load) begin
      crc_r <= short_sel ? {8'h00, seed[7:0]} : seed; // [RL18]
    end else if (byte_valid) begin
      crc_r <= c;
    end
  end
endmodule
`default_nettype wire

/* src/nvm_cmd_consts.vh */
// Constants for the non-volatile memory and checksum command engine
`ifndef NVM_CMD_CONSTS_VH
`define NVM_CMD_CONSTS_VH
// Command codes
`define CMD_IDLE 8'h00
`define CMD_NVM_PROGRAM 8'h01
`define CMD_NVM_FETCH 8'h03
`define CMD_SETTINGS_RESTORE 8'h07
`define CMD_CHECKSUM_COMPUTE 8'h12
// Register offsets (byte addresses)
`define REG_COMMAND 8'h00
`define REG_STATUS 8'h04
`define REG_FIFO_DATA 8'h08
`define REG_CRC_CFG 8'h0c
`define REG_CRC_SEED 8'h10
`define REG_CRC_VALUE 8'h14
`define REG_CONFIG_BASE 8'h40
`define REG_CONFIG_LAST 8'hbc
// Status bit positions
`define ST_PROGRAM_DONE 0
`define ST_TX_IRQ 1
`define ST_ACCESS_FAULT 2
`define ST_CRC_MISMATCH 3
`define ST_CRC_DONE 4
`define ST_ERR 5
`define ST_BUSY 6
// Checksum configuration bits
`define CFG_SHORT 0
`define CFG_ALGO 1
`define CFG_MSB_FIRST 2
`define CFG_RESET 3'h3
// Memory geometry
`define NVM_BLOCK_BYTES 16
`define NVM_PROTECTED_LAST 11'h00f
`define CONFIG_BYTES 32
`define FIFO_DEPTH 64
// Programming time
`define PROG_TIME_NS 5800000
`define CLK_PERIOD_NS 8
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
// Polynomials
`define POLY8 8'h1d
`define POLY16 16'h1021
`endif

/* src/nvm_cmd_engine.v */
// Command engine for EEPROM program/fetch, settings restore and CRC
// Operation
// [RL1] Program cmd 01h: two address bytes low first, then data sequentially.
// [RL2] Program cmd returns nothing, runs until Idle is written.
// [RL3] One programming cycle writes 1..16 bytes, about 5.8 ms.
// [RL4] Bytes go to 16-byte buffer; cycle starts on block end or FIFO empty.
// [RL5] Done flag low while bytes pending or programming; rise sets irq flag.
// [RL6] No other command may interrupt programming while done flag is low.
// [RL7] Host must wait for done flag before starting another command.
// [RL8] After programming, stay in command; new bytes continue at next address.
// [RL9] Writes to addresses 00h..0Fh set access fault, no cycle started.
// [RL10] Fetch cmd 03h: two address bytes then byte count.
// [RL11] With all arguments present copy bytes into FIFO, then end.
// [RL12] Restore cmd 07h: two address bytes, low first.
// [RL13] Copy 32 bytes into config registers 10h..2Fh, then stop.
// [RL14] Host supplies restore start addresses 10h..60h only.
// [RL15] Checksum cmd 12h feeds every FIFO byte, including earlier ones.
// [RL16] Checksum returns no data; value readable in result registers.
// [RL17] Checksum waits on empty FIFO, ends only on Idle.
// [RL18] Checksum length, algorithm, bit order and seed are configurable. The algorithm bit is stored but not used.
// [RL19] 8-bit polynomial x^8+x^4+x^3+x^2+1.
// [RL20] 16-bit polynomial x^16+x^12+x^5+1.
// [RL21] Checksum done flag set when FIFO consumed; also sets irq flag.
// [RL22] Result and mismatch flag valid when done and irq flags high.
// [RL23] Any command error sets the general error bit.
// [RL24] Consumed argument bytes leave the FIFO in order.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`include "nvm_cmd_consts.vh"
`default_nettype none
module nvm_cmd_engine #(
  parameter PROG_CYCLES = `PROG_CYCLES
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // ****************************************
  // Storage
  // ****************************************
  localparam S_IDLE = 6'b000001;
  localparam S_PROG = 6'b000010;
  localparam S_BURN = 6'b000100;
  localparam S_FETCH = 6'b001000;
  localparam S_RESTORE = 6'b010000;
  localparam S_CRC = 6'b100000;

  reg [7:0] nvm_mem [0:2047];
  reg [7:0] fifo_mem [0:`FIFO_DEPTH-1];
  reg [7:0] cfg_mem [0:`CONFIG_BYTES-1];
  reg [7:0] pbuf [0:`NVM_BLOCK_BYTES-1];
  reg [5:0] state_r;
  reg [5:0] rd_ptr_r, wr_ptr_r;
  reg [6:0] count_r;
  reg [10:0] addr_r, blk_addr_r;
  reg [4:0] pcnt_r;
  reg [7:0] left_r;
  reg [1:0] argn_r;
  reg [22:0] tmr_r;
  reg [2:0] cfg_r;
  reg [15:0] seed_r;
  reg done_r, irq_r, fault_r, mism_r, crcd_r, err_r;
  reg crc_load_r;
  reg crc_last_r;
  reg [7:0] cmd_pend_r;
  reg cmd_req_r;
  reg push_bus_r;
  reg [7:0] push_data_r;
  reg pop_bus_r;
  reg [7:0] pop_q_r;
  wire [15:0] crc_val;
  integer k;

  wire fifo_empty = (count_r == 7'd0);
  wire fifo_full = (count_r == 7'd64);
  wire [7:0] head = fifo_mem[rd_ptr_r];
  wire busy_prog = (state_r == S_BURN) | (state_r == S_PROG & ~done_r);

  // Engine side FIFO pops and pushes, decided in the command machine
  reg eng_pop, eng_push;
  reg [7:0] eng_data;

  // ****************************************
  // Bus slave
  // ****************************************
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid &
               ~s_axi_awready;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
  wire [7:0] waddr = s_axi_awaddr;
  wire [7:0] raddr = s_axi_araddr;
  wire cfg_w = wr_go & (waddr >= `REG_CONFIG_BASE) &
               (waddr <= `REG_CONFIG_LAST);

  // Write channel: take address and data together, one-cycle answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      cmd_req_r <= 1'b0;
      cmd_pend_r <= 8'h00;
      push_bus_r <= 1'b0;
      push_data_r <= 8'h00;
      cfg_r <= `CFG_RESET;
      seed_r <= 16'hffff;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      cmd_req_r <= 1'b0;
      push_bus_r <= 1'b0;
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'b00;
        if (waddr == `REG_COMMAND && s_axi_wstrb[0]) begin
          cmd_req_r <= 1'b1;
          cmd_pend_r <= s_axi_wdata[7:0];
        end else if (waddr == `REG_FIFO_DATA && s_axi_wstrb[0]) begin
          push_bus_r <= 1'b1;
          push_data_r <= s_axi_wdata[7:0];
        end else if (waddr == `REG_CRC_CFG && s_axi_wstrb[0]) begin
          cfg_r <= s_axi_wdata[2:0];
        end else if (waddr == `REG_CRC_SEED) begin
          if (s_axi_wstrb[0]) seed_r[7:0] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) seed_r[15:8] <= s_axi_wdata[15:8];
        end else if (!cfg_w && waddr != `REG_STATUS &&
                     waddr != `REG_CRC_VALUE) begin
          s_axi_bresp <= 2'b10; // Unmapped slave error
        end
      end
    end
  end

  // Read channel; a data register read in Idle pops one FIFO byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
      pop_bus_r <= 1'b0;
    end else begin
      s_axi_arready <= rd_go;
      pop_bus_r <= 1'b0;
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h00000000;
        if (raddr == `REG_COMMAND) begin
          s_axi_rdata <= {26'h0, state_r};
        end else if (raddr == `REG_STATUS) begin
          s_axi_rdata <= {18'h0, count_r, busy_prog, err_r, crcd_r,
                          mism_r, fault_r, irq_r, done_r};
        end else if (raddr == `REG_FIFO_DATA) begin
          s_axi_rdata <= {24'h0, head};
          pop_bus_r <= ~fifo_empty & (state_r == S_IDLE);
        end else if (raddr == `REG_CRC_CFG) begin
          s_axi_rdata <= {29'h0, cfg_r};
        end else if (raddr == `REG_CRC_SEED) begin
          s_axi_rdata <= {16'h0, seed_r};
        end else if (raddr == `REG_CRC_VALUE) begin
          s_axi_rdata <= {16'h0, crc_val}; // [RL16]
        end else if (raddr >= `REG_CONFIG_BASE &&
                     raddr <= `REG_CONFIG_LAST) begin
          // Word 40h holds register 10h, so rebase the word index
          s_axi_rdata <= {24'h0, cfg_mem[{raddr[7], raddr[5:2]}]};
        end else begin
          s_axi_rresp <= 2'b10;
        end
      end
    end
  end

  // ****************************************
  // Byte FIFO shared by host and engine
  // ****************************************
  wire do_pop = eng_pop | pop_bus_r;
  wire do_push = (eng_push | push_bus_r) & ~fifo_full;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr_r <= 6'd0;
      wr_ptr_r <= 6'd0;
      count_r <= 7'd0;
    end else begin
      if (do_push) begin
        fifo_mem[wr_ptr_r] <= eng_push ? eng_data : push_data_r;
        wr_ptr_r <= wr_ptr_r + 6'd1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 6'd1; // [RL24]
      end
      count_r <= count_r + {6'd0, do_push} - {6'd0, do_pop};
    end
  end

  // ****************************************
  // Command machine
  // ****************************************
  wire accept_cmd = cmd_req_r & ~busy_prog; // [RL6]
  always @* begin
    eng_pop = 1'b0;
    eng_push = 1'b0;
    eng_data = nvm_mem[addr_r];
    case (state_r)
      S_PROG: eng_pop = ~fifo_empty & ~accept_cmd;
      S_FETCH: begin
        eng_pop = (argn_r != 2'd3) & ~fifo_empty;
        eng_push = (argn_r == 2'd3) & (left_r != 8'd0) & ~fifo_full;
      end
      S_RESTORE: eng_pop = (argn_r != 2'd2) & ~fifo_empty;
      S_CRC: eng_pop = ~fifo_empty & ~crc_load_r & ~accept_cmd; // [RL15]
      default: begin
        eng_pop = 1'b0;
      end
    endcase
  end

  checksum_engine crc_u (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(crc_load_r),
    .seed(seed_r),
    .short_sel(cfg_r[`CFG_SHORT]),
    .msb_first(cfg_r[`CFG_MSB_FIRST]),
    .byte_valid(state_r == S_CRC & eng_pop),
    .byte_in(head),
    .crc_r(crc_val)
  );

  // Main sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE;
      addr_r <= 11'd0;
      blk_addr_r <= 11'd0;
      pcnt_r <= 5'd0;
      left_r <= 8'd0;
      argn_r <= 2'd0;
      tmr_r <= 23'd0;
      done_r <= 1'b0;
      irq_r <= 1'b0;
      fault_r <= 1'b0;
      mism_r <= 1'b0;
      crcd_r <= 1'b0;
      err_r <= 1'b0;
      crc_load_r <= 1'b0;
      crc_last_r <= 1'b0;
    end else begin
      crc_load_r <= 1'b0;
      crc_last_r <= 1'b0;
      if (accept_cmd) begin
        argn_r <= 2'd0;
        done_r <= 1'b0;
        crcd_r <= 1'b0;
        irq_r <= 1'b0;
        fault_r <= 1'b0;
        mism_r <= 1'b0;
        err_r <= 1'b0;
        case (cmd_pend_r)
          `CMD_NVM_PROGRAM: state_r <= S_PROG; // [RL1]
          `CMD_NVM_FETCH: state_r <= S_FETCH; // [RL10]
          `CMD_SETTINGS_RESTORE: state_r <= S_RESTORE; // [RL12]
          `CMD_CHECKSUM_COMPUTE: begin
            state_r <= S_CRC;
            crc_load_r <= 1'b1;
          end
          default: state_r <= S_IDLE; // Idle stops endless commands
        endcase
      end else begin
        case (state_r)
          S_PROG: begin
            if (eng_pop && argn_r == 2'd0) begin
              addr_r[7:0] <= head;
              argn_r <= 2'd1;
            end else if (eng_pop && argn_r == 2'd1) begin
              addr_r[10:8] <= head[2:0];
              argn_r <= 2'd2;
              pcnt_r <= 5'd0;
            end else if (eng_pop) begin
              done_r <= 1'b0; // [RL5]
              if (pcnt_r == 5'd0) blk_addr_r <= addr_r;
              pbuf[addr_r[3:0]] <= head; // [RL4]
              pcnt_r <= pcnt_r + 5'd1;
              addr_r <= addr_r + 11'd1; // [RL8]
              if (addr_r[3:0] == 4'hf || count_r == 7'd1) begin
                if (addr_r <= `NVM_PROTECTED_LAST) begin
                  fault_r <= 1'b1; // [RL9]
                  err_r <= 1'b1; // [RL23]
                  pcnt_r <= 5'd0;
                  done_r <= 1'b1;
                  irq_r <= 1'b1;
                end else begin
                  tmr_r <= PROG_CYCLES[22:0]; // [RL3]
                  state_r <= S_BURN;
                end
              end
            end
          end
          S_BURN: begin
            if (tmr_r != 23'd0) begin
              tmr_r <= tmr_r - 23'd1;
            end else begin
              for (k = 0; k < `NVM_BLOCK_BYTES; k = k + 1) begin
                if (k[3:0] >= blk_addr_r[3:0] &&
                    k < blk_addr_r[3:0] + pcnt_r) begin
                  nvm_mem[{blk_addr_r[10:4], k[3:0]}] <= pbuf[k];
                end
              end
              pcnt_r <= 5'd0;
              state_r <= S_PROG; // [RL2]
              if (fifo_empty) begin
                done_r <= 1'b1; // [RL5]
                irq_r <= 1'b1;
              end
            end
          end
          S_FETCH: begin
            if (eng_pop) begin
              case (argn_r)
                2'd0: addr_r[7:0] <= head;
                2'd1: addr_r[10:8] <= head[2:0];
                default: left_r <= head;
              endcase
              argn_r <= argn_r + 2'd1;
            end else if (eng_push) begin
              addr_r <= addr_r + 11'd1; // [RL11]
              left_r <= left_r - 8'd1;
            end else if (argn_r == 2'd3 && left_r == 8'd0) begin
              state_r <= S_IDLE;
            end
          end
          S_RESTORE: begin
            if (eng_pop) begin
              if (argn_r == 2'd0) addr_r[7:0] <= head;
              else addr_r[10:8] <= head[2:0];
              argn_r <= argn_r + 2'd1;
              left_r <= 8'd0;
            end else if (argn_r == 2'd2) begin
              cfg_mem[left_r[4:0]] <= nvm_mem[addr_r]; // [RL13]
              addr_r <= addr_r + 11'd1;
              left_r <= left_r + 8'd1;
              if (left_r == `CONFIG_BYTES - 1) state_r <= S_IDLE;
            end
          end
          S_CRC: begin
            // [RL17] waits on empty FIFO until Idle
            // Done waits a cycle so result and mismatch settle with it
            crc_last_r <= eng_pop & (count_r == 7'd1) & ~push_bus_r;
            if (crc_last_r) begin
              crcd_r <= 1'b1; // [RL21]
              irq_r <= 1'b1;
            end else if (eng_pop) begin
              crcd_r <= 1'b0;
            end
            // Residue check: zero remainder means data plus CRC agree
            mism_r <= (crc_val != 16'h0000); // [RL22]
            if (mism_r & crcd_r) err_r <= 1'b1;
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* verification/host_axi_master.sv */
// Bus master model standing in for the host processor
`default_nettype none
module host_axi_master (
  // Clock
  input wire logic aclk,
  // Write request
  output logic [7:0] awaddr,
  output logic awvalid,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  output logic bready,
  // Write answer
  input wire logic awready,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  // Read
  output logic [7:0] araddr,
  output logic arvalid,
  output logic rready,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  // Each channel released only on its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask
  // Read waits for rvalid, however long it takes
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verification/nvm_cmd_engine_assertions.sv */
// Checker for the command engine register port
`include "nvm_cmd_consts.vh"
`default_nettype none
module nvm_cmd_engine_checker #(
  parameter PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write side
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read side
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [7:0] wa_r;
  logic [7:0] ra_r;
  logic st;
  // Remember addresses in flight, so responses can be judged
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
      wa_r <= s_axi_awaddr;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      ra_r <= s_axi_araddr;
    end
  end
  assign st = s_axi_rvalid && ra_r == `REG_STATUS;
  // Gaps in the map answer with a slave error
  function automatic logic [1:0] resp_of(input logic [7:0] a);
    if (a[1:0] == 2'b00 && (a <= 8'h14 || (a >= 8'h40 && a <= 8'hbc))) begin
      return 2'b00;
    end
    return 2'b10;
  endfunction
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence s_wr_ans;
    s_axi_awready && s_axi_wready && s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_wr_ans)
    else $error("write not answered next cycle");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered next cycle");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid)
    else $error("bvalid kept after handshake");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid)
    else $error("rvalid kept after handshake");
  a_write_resp: assert property (s_axi_bvalid |-> s_axi_bresp == resp_of(wa_r))
    else $error("wrong write response");
  a_read_resp: assert property (s_axi_rvalid |-> s_axi_rresp == resp_of(ra_r))
    else $error("wrong read response");
  a_fault_err: assert property (st && s_axi_rdata[`ST_ACCESS_FAULT]
    |-> s_axi_rdata[`ST_ERR])
    else $error("access fault without error bit");
  a_crc_irq: assert property (st && s_axi_rdata[`ST_CRC_DONE]
    |-> s_axi_rdata[`ST_TX_IRQ])
    else $error("checksum done without irq flag");
endmodule
bind nvm_cmd_engine nvm_cmd_engine_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);
`default_nettype wire

/* verification/nvm_cmd_engine_tb_top.sv */
// Self-checking bench for the command engine
`include "nvm_cmd_consts.vh"
`default_nettype none
module nvm_cmd_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv, idle_code;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  byte unsigned mem [int];
  // Short programming time keeps the run brief
  nvm_cmd_engine #(.PROG_CYCLES(20)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  host_axi_master host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .bready(bready), .awready(awready),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .araddr(araddr),
    .arvalid(arvalid), .rready(rready), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid)
  );
  // Clock, and a cycle ceiling that cuts a hang short
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    host.wr(a, d, rsp);
    check(rsp, 2'b00);
  endtask
  // Poll until masked bits match; only the ceiling bounds it
  task automatic wait_for(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] v);
    do host.rd(a, rdv, rsp); while ((rdv & m) !== v);
  endtask
  // Reference checksum, one byte shifted in MSB first
  function automatic int crc_step(input int c, input int b, input int w);
    int poly;
    poly = (w == 8) ? 'h1d : 'h1021;
    for (int k = 7; k >= 0; k--) begin
      c = (c << 1) ^ ((c[w-1] ^ b[k]) ? poly : 0);
    end
    return c & ((1 << w) - 1);
  endfunction
  // *****
  // Main sequence
  // *****
  initial begin
    int w, c, t;
    logic [7:0] d [$];
    void'($urandom(14));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    host.rd(`REG_COMMAND, idle_code, rsp);
    host.rd(`REG_CRC_CFG, rdv, rsp);
    check(rdv[2:0], `CFG_RESET);
    host.rd(`REG_CRC_SEED, rdv, rsp);
    check(rdv[15:0], 16'hffff);
    host.rd(8'h30, rdv, rsp);
    check(rsp, 2'b10);
    // Checksum: both widths, plain data and data with its own check
    for (int run = 0; run < 4; run++) begin
      w = run[1] ? 8 : 16;
      t = $urandom & ((1 << w) - 1);
      put(`REG_CRC_CFG, {29'h0, 2'b11, run[1]});
      put(`REG_CRC_SEED, t);
      c = t;
      d = {};
      repeat (4) d.push_back(8'($urandom));
      foreach (d[i]) c = crc_step(c, d[i], w);
      if (run[0]) begin
        if (w == 16) d.push_back(8'(c >> 8));
        d.push_back(8'(c));
      end
      c = t;
      foreach (d[i]) c = crc_step(c, d[i], w);
      foreach (d[i]) begin
        if (i == 2) put(`REG_COMMAND, `CMD_CHECKSUM_COMPUTE);
        put(`REG_FIFO_DATA, d[i]);
      end
      wait_for(`REG_STATUS, 32'h12, 32'h12);
      host.rd(`REG_CRC_VALUE, rdv, rsp);
      check(rdv & ((1 << w) - 1), c);
      host.rd(`REG_STATUS, rdv, rsp);
      check(rdv[`ST_CRC_MISMATCH], c != 0);
      host.rd(`REG_COMMAND, rdv, rsp);
      check(rdv !== idle_code, 1'b1);
      put(`REG_COMMAND, `CMD_IDLE);
    end
    // Program six bytes across a block edge, the last after a pause
    put(`REG_COMMAND, `CMD_NVM_PROGRAM);
    put(`REG_FIFO_DATA, 8'h4c);
    put(`REG_FIFO_DATA, 8'h00);
    for (int a = 'h4c; a <= 'h51; a++) begin
      mem[a] = 8'($urandom);
      put(`REG_FIFO_DATA, mem[a]);
      if (a == 'h50) wait_for(`REG_STATUS, 32'h3, 32'h3);
    end
    // Programming must take at least the programmed cycle count
    t = cycles;
    host.rd(`REG_STATUS, rdv, rsp);
    check(rdv[`ST_PROGRAM_DONE], 1'b0);
    wait_for(`REG_STATUS, 32'h3, 32'h3);
    check(cycles - t > 20, 1'b1);
    put(`REG_COMMAND, `CMD_IDLE);
    // Fetch the bytes back; the command ends by itself
    put(`REG_COMMAND, `CMD_NVM_FETCH);
    put(`REG_FIFO_DATA, 8'h4c);
    put(`REG_FIFO_DATA, 8'h00);
    put(`REG_FIFO_DATA, 8'h06);
    wait_for(`REG_COMMAND, 32'hffffffff, idle_code);
    for (int a = 'h4c; a <= 'h51; a++) begin
      host.rd(`REG_FIFO_DATA, rdv, rsp);
      check(rdv[7:0], mem[a]);
    end
    // Restore settings from the same bytes, start address in range
    put(`REG_COMMAND, `CMD_SETTINGS_RESTORE);
    put(`REG_FIFO_DATA, 8'h4c);
    put(`REG_FIFO_DATA, 8'h00);
    wait_for(`REG_COMMAND, 32'hffffffff, idle_code);
    for (int i = 0; i < 6; i++) begin
      host.rd(8'(`REG_CONFIG_BASE + 4 * i), rdv, rsp);
      check(rdv[7:0], mem['h4c + i]);
    end
    // A clean command leaves the error bit clear
    host.rd(`REG_STATUS, rdv, rsp);
    check(rdv[`ST_ERR], 1'b0);
    // Protected block last; its data byte is popped but starts no programming cycle
    put(`REG_COMMAND, `CMD_NVM_PROGRAM);
    put(`REG_FIFO_DATA, 8'h05);
    put(`REG_FIFO_DATA, 8'h00);
    put(`REG_FIFO_DATA, 8'h5a);
    wait_for(`REG_STATUS, 32'h4, 32'h4);
    check(rdv[`ST_ERR], 1'b1);
    put(`REG_COMMAND, `CMD_IDLE);
    close_out();
  end
endmodule
`default_nettype wire
